// ===== rtl/firs_cfg.svh
`ifndef FIRS_CFG_SVH
`define FIRS_CFG_SVH
// Opcodes
`define FIRS_OP_ROW_READ     8'h68
`define FIRS_OP_SECTOR_OPEN  8'h26
`define FIRS_OP_SECTOR_CLOSE 8'h24
// Frame field end counts in serial clocks
`define FIRS_OPC_BITS        6'h08
`define FIRS_ADDR_END        6'h20
`define FIRS_DUMMY_END       6'h28
// Row geometry
`define FIRS_ROW_LAST        8'hff
`define FIRS_ROW_BITS        10
`define FIRS_ROW_MSB         13
`define FIRS_ROW_LSB         12
`define FIRS_SECT_LSB        12
// Timing
`define FIRS_CLK_MHZ         40
`define FIRS_LINK_MHZ        104
// Fifo
`define FIRS_FIFO_DEPTH      32
`define FIRS_FIFO_AW         5
`endif

// ===== rtl/firs_pkg.sv
package firs_pkg;
    // Command decoder states
    typedef enum logic [4:0] {
        FIRS_IDLE  = 5'b00001,
        FIRS_OPC   = 5'b00010,
        FIRS_ADDR  = 5'b00100,
        FIRS_DATA  = 5'b01000,
        FIRS_SKIP  = 5'b10000
    } firs_state_e;

    // Serial pins as seen by the device
    typedef struct packed {
        logic ce_n;
        logic sck;
        logic si;
    } firs_pins_s;

    // Sector selection
    typedef struct packed {
        logic        open;
        logic [11:0] sector;
    } firs_sect_s;
endpackage : firs_pkg

// ===== rtl/firs_fifo.sv
`timescale 1ns/1ps
module firs_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32,
    parameter int AW    = 5
) (
    input  wire logic             mclk_i,
    input  wire logic             rst_n_i,
    input  wire logic             flush_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    output logic      [WIDTH-1:0] out_data_o,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_reg;
    logic [AW:0]      rd_reg;
    logic             push;
    logic             pop;

    // Honest full and empty from pointer difference
    assign out_valid_o = (wr_reg != rd_reg);
    assign in_ready_o  = (wr_reg[AW] == rd_reg[AW]) ||
                         (wr_reg[AW-1:0] != rd_reg[AW-1:0]);
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;
    assign out_data_o  = mem[rd_reg[AW-1:0]];

    // Storage
    always_ff @(posedge mclk_i) begin
        if (push) begin
            mem[wr_reg[AW-1:0]] <= in_data_i;
        end
    end

    // Pointers
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_reg <= '0;
            rd_reg <= '0;
        end else if (flush_i) begin
            wr_reg <= '0;
            rd_reg <= '0;
        end else begin
            if (push) begin
                wr_reg <= wr_reg + 1'b1;
            end
            if (pop) begin
                rd_reg <= rd_reg + 1'b1;
            end
        end
    end
endmodule : firs_fifo

// ===== rtl/firs_top.sv
// Behaviour
// - Opcode 68h starts an information-row read.
// - Row read works at serial clocks up to the fast limit; the code samples sck with mclk, so sck must stay below 20 MHz.
// - Opcode, address and dummy bits sampled on rising serial clock.
// - Data bits driven onto serial output on falling serial clock.
// - Byte address advances by one after each byte shifted out.
// - Past the last byte of a row the data is undefined.
// - Chip enable high ends the read and stops output driving.
// - Row read ignored while a program, erase or write cycle runs.
// - Opcode 26h unlocks one sector for program and erase.
// - Unlock applies only inside blocks marked protected by protect bits; the code locks every sector but the open one when any protect bit is set.
// - Only one sector open; a new unlock replaces the old one.
// - Unlock takes 24 address bits; bits 0 to 11 are ignored.
// - Other sectors of the protected block stay read-only.
// - Opcode 24h relocks the open sector.
// - Lock command is the opcode alone, no address.
// - Write-in-progress flag is 1 during program or erase, else 0.
`timescale 1ns/1ps
`include "firs_cfg.svh"
module firs_top (
    input  wire logic             mclk_i,
    input  wire logic             rst_n_i,
    input  wire firs_pkg::firs_pins_s pins_i,
    output logic                  so_o,
    output logic                  so_oe_o,
    input  wire logic             write_in_progress_flag_i,
    input  wire logic             block_protect_bit0_i,
    input  wire logic             block_protect_bit1_i,
    input  wire logic             block_protect_bit2_i,
    input  wire logic             block_protect_bit3_i,
    input  wire logic [11:0]      wr_sector_i,
    output logic                  wr_allowed_o,
    output logic                  sector_open_o,
    output logic [11:0]           open_sector_o,
    output logic                  write_in_progress_flag_o,
    output logic [`FIRS_ROW_BITS-1:0] rom_addr_o,
    input  wire logic [7:0]       rom_data_i
);
    import firs_pkg::*;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [2:0] meta_reg;
    logic [2:0] sync_reg;
    logic       sck_d_reg;
    logic       wip_meta_reg;
    logic       wip_reg;
    logic [3:0] bp_meta_reg;
    logic [3:0] bp_reg;

    // Two flops on every pin and status input
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_reg     <= 3'h4;
            sync_reg     <= 3'h4;
            sck_d_reg    <= 1'b0;
            wip_meta_reg <= 1'b0;
            wip_reg      <= 1'b0;
            bp_meta_reg  <= 4'h0;
            bp_reg       <= 4'h0;
        end else begin
            meta_reg     <= {pins_i.ce_n, pins_i.sck, pins_i.si};
            sync_reg     <= meta_reg;
            sck_d_reg    <= sync_reg[1];
            wip_meta_reg <= write_in_progress_flag_i;
            wip_reg      <= wip_meta_reg;
            bp_meta_reg  <= {block_protect_bit3_i, block_protect_bit2_i,
                             block_protect_bit1_i, block_protect_bit0_i};
            bp_reg       <= bp_meta_reg;
        end
    end

    logic ce_n;
    logic si;
    logic rise;
    logic fall;
    assign ce_n = sync_reg[2];
    assign si   = sync_reg[0];
    assign rise = sync_reg[1] && !sck_d_reg;
    assign fall = !sync_reg[1] && sck_d_reg;

    // ------------------------------------------------------------
    // Command decoder
    // ------------------------------------------------------------
    firs_state_e state_reg;
    logic [5:0]  cnt_reg;
    logic [7:0]  opc_reg;
    logic [23:0] addr_reg;
    logic [2:0]  bit_reg;
    logic [`FIRS_ROW_BITS-1:0] rd_addr_reg;
    logic [7:0]  opc_next;
    logic [23:0] addr_next;
    assign opc_next  = {opc_reg[6:0], si};
    assign addr_next = {addr_reg[22:0], si};

    // Bit counter and frame sequencing
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg <= FIRS_IDLE;
            cnt_reg   <= 6'h00;
            opc_reg   <= 8'h00;
            addr_reg  <= 24'h000000;
        end else if (ce_n) begin
            state_reg <= FIRS_IDLE;
            cnt_reg   <= 6'h00;
        end else begin
            case (state_reg)
                FIRS_IDLE: begin
                    state_reg <= FIRS_OPC;
                    cnt_reg   <= 6'h00;
                end
                FIRS_OPC: begin
                    if (rise) begin
                        opc_reg <= opc_next;
                        cnt_reg <= cnt_reg + 6'h01;
                        if (cnt_reg == `FIRS_OPC_BITS - 6'h01) begin
                            if (opc_next == `FIRS_OP_SECTOR_OPEN ||
                                (opc_next == `FIRS_OP_ROW_READ &&
                                 !wip_reg)) begin
                                state_reg <= FIRS_ADDR;
                            end else begin
                                state_reg <= FIRS_SKIP;
                            end
                        end
                    end
                end
                FIRS_ADDR: begin
                    if (rise) begin
                        cnt_reg <= cnt_reg + 6'h01;
                        if (cnt_reg < `FIRS_ADDR_END) begin
                            addr_reg <= addr_next;
                        end
                        if (opc_reg == `FIRS_OP_SECTOR_OPEN &&
                            cnt_reg == `FIRS_ADDR_END - 6'h01) begin
                            state_reg <= FIRS_SKIP;
                        end
                        if (cnt_reg == `FIRS_DUMMY_END - 6'h01) begin
                            state_reg <= FIRS_DATA;
                        end
                    end
                end
                FIRS_DATA: begin
                    state_reg <= FIRS_DATA;
                end
                FIRS_SKIP: begin
                    state_reg <= FIRS_SKIP;
                end
                default: begin
                    state_reg <= FIRS_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Row read data path through the byte buffer
    // ------------------------------------------------------------
    logic       fetch_reg;
    logic       fifo_in_ready;
    logic [7:0] fifo_data;
    logic       fifo_valid;
    logic       fifo_pop;
    logic [7:0] shift_reg;
    logic       loaded_reg;
    logic       push_reg;

    // Prefetch row bytes while the buffer has room
    // One fetch in flight at most, so a full buffer never drops a byte
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_addr_reg <= '0;
            fetch_reg   <= 1'b0;
        end else if (state_reg != FIRS_DATA) begin
            rd_addr_reg <= {addr_reg[`FIRS_ROW_MSB:`FIRS_ROW_LSB],
                            addr_reg[7:0]};
            fetch_reg   <= 1'b0;
        end else if (fifo_in_ready && !push_reg) begin
            fetch_reg <= 1'b1;
            if (fetch_reg) begin
                rd_addr_reg <= rd_addr_reg + 1'b1;
            end
        end
    end

    // Memory address follows the prefetch pointer
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rom_addr_o <= '0;
        end else begin
            rom_addr_o <= rd_addr_reg;
        end
    end

    // Buffer write one cycle after the memory address is issued
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            push_reg <= 1'b0;
        end else begin
            push_reg <= (state_reg == FIRS_DATA) && fetch_reg &&
                        fifo_in_ready && !push_reg;
        end
    end

    firs_fifo #(
        .WIDTH (8),
        .DEPTH (`FIRS_FIFO_DEPTH),
        .AW    (`FIRS_FIFO_AW)
    ) u_fifo (
        .mclk_i      (mclk_i),
        .rst_n_i     (rst_n_i),
        .flush_i     (state_reg != FIRS_DATA),
        .in_data_i   (rom_data_i),
        .in_valid_i  (push_reg),
        .in_ready_o  (fifo_in_ready),
        .out_data_o  (fifo_data),
        .out_valid_o (fifo_valid),
        .out_ready_i (fifo_pop)
    );

    assign fifo_pop = fall && (bit_reg == 3'h0) && fifo_valid &&
                      (state_reg == FIRS_DATA);

    // Serial shifter, one bit per falling edge
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            shift_reg  <= 8'h00;
            bit_reg    <= 3'h0;
            loaded_reg <= 1'b0;
            so_o       <= 1'b0;
        end else if (state_reg != FIRS_DATA) begin
            bit_reg    <= 3'h0;
            loaded_reg <= 1'b0;
        end else if (fall) begin
            if (bit_reg == 3'h0) begin
                so_o       <= fifo_data[7];
                shift_reg  <= {fifo_data[6:0], 1'b0};
                loaded_reg <= fifo_valid;
            end else begin
                so_o      <= shift_reg[7];
                shift_reg <= {shift_reg[6:0], 1'b0};
            end
            bit_reg <= bit_reg + 3'h1;
        end
    end

    // Output enable only in the data phase
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            so_oe_o <= 1'b0;
        end else begin
            so_oe_o <= (state_reg == FIRS_DATA) && !ce_n &&
                       (fall || so_oe_o);
        end
    end

    // ------------------------------------------------------------
    // Sector lock and unlock
    // ------------------------------------------------------------
    firs_sect_s sect_reg;
    logic       close_hit;
    logic       open_hit;
    assign close_hit = (state_reg == FIRS_OPC) && rise &&
                       cnt_reg == `FIRS_OPC_BITS - 6'h01 &&
                       opc_next == `FIRS_OP_SECTOR_CLOSE;
    assign open_hit  = (state_reg == FIRS_ADDR) && rise &&
                       opc_reg == `FIRS_OP_SECTOR_OPEN &&
                       cnt_reg == `FIRS_ADDR_END - 6'h01;

    // Single open sector register
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sect_reg <= '0;
        end else if (open_hit) begin
            sect_reg.open   <= 1'b1;
            sect_reg.sector <= addr_next[23:`FIRS_SECT_LSB];
        end else if (close_hit) begin
            sect_reg.open <= 1'b0;
        end
    end

    // Write permission for the array write engine
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_allowed_o             <= 1'b0;
            sector_open_o            <= 1'b0;
            open_sector_o            <= 12'h000;
            write_in_progress_flag_o <= 1'b0;
        end else begin
            wr_allowed_o  <= (bp_reg == 4'h0) ||
                             (sect_reg.open &&
                              sect_reg.sector == wr_sector_i);
            sector_open_o <= sect_reg.open;
            open_sector_o <= sect_reg.sector;
            write_in_progress_flag_o <= wip_reg;
        end
    end
endmodule : firs_top

// ===== tb/firs_top_asserts.sv
`timescale 1ns/1ps
module firs_top_asserts (
    input wire logic                 mclk_i,
    input wire logic                 rst_n_i,
    input wire firs_pkg::firs_pins_s pins_i,
    input wire logic                 so_oe_o,
    input wire logic                 write_in_progress_flag_i,
    input wire logic                 block_protect_bit0_i,
    input wire logic                 block_protect_bit1_i,
    input wire logic                 block_protect_bit2_i,
    input wire logic                 block_protect_bit3_i,
    input wire logic [11:0]          wr_sector_i,
    input wire logic                 wr_allowed_o,
    input wire logic                 sector_open_o,
    input wire logic [11:0]          open_sector_o,
    input wire logic                 write_in_progress_flag_o,
    input wire logic [9:0]           rom_addr_o
);
    import firs_pkg::*;
    logic [7:0] rise_cnt_reg;
    logic [8:0] wip_cnt_reg;
    logic [3:0] bp;
    assign bp = {block_protect_bit3_i, block_protect_bit2_i,
                 block_protect_bit1_i, block_protect_bit0_i};
    // Serial clock rises seen in the current frame
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) rise_cnt_reg <= 8'h00;
        else if (pins_i.ce_n) rise_cnt_reg <= 8'h00;
        else if ($rose(pins_i.sck) && rise_cnt_reg != 8'hff)
            rise_cnt_reg <= rise_cnt_reg + 8'h01;
    end
    // Length of the current busy stretch, saturating
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) wip_cnt_reg <= 9'h000;
        else if (!write_in_progress_flag_i) wip_cnt_reg <= 9'h000;
        else if (wip_cnt_reg != 9'h1ff) wip_cnt_reg <= wip_cnt_reg + 9'h001;
    end
    // ------
    // Properties
    // ------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    property p_oe_off; pins_i.ce_n [*6] |-> !so_oe_o; endproperty
    property p_busy_read; $rose(so_oe_o) |-> wip_cnt_reg < 9'h190; endproperty
    property p_busy_flag;
        $stable(write_in_progress_flag_i) [*5]
        |-> write_in_progress_flag_o == write_in_progress_flag_i;
    endproperty
    property p_open_at;
        ($rose(sector_open_o) || $changed(open_sector_o)) && sector_open_o
        |-> !pins_i.ce_n && rise_cnt_reg inside {[8'h20:8'h21]};
    endproperty
    property p_close_at;
        $fell(sector_open_o) |-> rise_cnt_reg inside {[8'h08:8'h09]};
    endproperty
    property p_wr_free; (bp == 4'h0) [*5] |-> wr_allowed_o; endproperty
    property p_wr_lock;
        ($stable(bp) && bp != 4'h0 && $stable(wr_sector_i)
         && $stable(open_sector_o) && $stable(sector_open_o)) [*5]
        |-> wr_allowed_o == (sector_open_o && wr_sector_i == open_sector_o);
    endproperty
    property p_addr_step;
        so_oe_o && $past(so_oe_o) && $changed(rom_addr_o)
        |-> rom_addr_o == $past(rom_addr_o) + 10'h001;
    endproperty
    property p_data_start;
        $rose(so_oe_o) |-> rise_cnt_reg inside {[8'h28:8'h29]};
    endproperty
    a_oe_off: assert property (p_oe_off)
        else $error("output enable held after frame end");
    a_busy_read: assert property (p_busy_read)
        else $error("read answered while busy");
    a_busy_flag: assert property (p_busy_flag)
        else $error("busy flag copy wrong");
    a_open_at: assert property (p_open_at)
        else $error("sector opened at wrong bit");
    a_close_at: assert property (p_close_at)
        else $error("sector closed at wrong bit");
    a_wr_free: assert property (p_wr_free)
        else $error("write refused without protection");
    a_wr_lock: assert property (p_wr_lock)
        else $error("write permission wrong");
    a_addr_step: assert property (p_addr_step)
        else $error("row address step wrong");
    a_data_start: assert property (p_data_start)
        else $error("data started at wrong clock");
    c_read: cover property ($rose(so_oe_o));
    c_open: cover property ($rose(sector_open_o));
    c_close: cover property ($fell(sector_open_o));
endmodule : firs_top_asserts

bind firs_top firs_top_asserts i_firs_top_asserts (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .pins_i(pins_i),
    .so_oe_o(so_oe_o),
    .write_in_progress_flag_i(write_in_progress_flag_i),
    .block_protect_bit0_i(block_protect_bit0_i),
    .block_protect_bit1_i(block_protect_bit1_i),
    .block_protect_bit2_i(block_protect_bit2_i),
    .block_protect_bit3_i(block_protect_bit3_i),
    .wr_sector_i(wr_sector_i), .wr_allowed_o(wr_allowed_o),
    .sector_open_o(sector_open_o), .open_sector_o(open_sector_o),
    .write_in_progress_flag_o(write_in_progress_flag_o),
    .rom_addr_o(rom_addr_o)
);

// ===== tb/firs_host.sv
`timescale 1ns/1ps
module firs_host (
    input  wire logic           mclk_i,
    output firs_pkg::firs_pins_s pins_o
);
    import firs_pkg::*;
    initial pins_o = 3'b100;
    // Released data line toggles so no stale bit is seen
    always @(negedge mclk_i) begin
        if (pins_o.ce_n) pins_o.si <= ~pins_o.si;
    end
    // Select low, clock idles low
    task automatic start_frame();
        @(negedge mclk_i);
        pins_o.ce_n <= 1'b0;
        pins_o.sck <= 1'b0;
        repeat (3) @(negedge mclk_i);
    endtask : start_frame
    // One byte, MSB first, four clocks low then four high
    task automatic send_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            @(negedge mclk_i);
            pins_o.sck <= 1'b0;
            pins_o.si <= b[i];
            repeat (4) @(negedge mclk_i);
            pins_o.sck <= 1'b1;
            repeat (3) @(negedge mclk_i);
        end
    endtask : send_byte
    // Last fall, then deselect
    task automatic end_frame();
        @(negedge mclk_i);
        pins_o.sck <= 1'b0;
        repeat (5) @(negedge mclk_i);
        pins_o.ce_n <= 1'b1;
        repeat (6) @(negedge mclk_i);
    endtask : end_frame
endmodule : firs_host

// ===== tb/tb_top.sv
`timescale 1ns/1ps
`include "firs_cfg.svh"
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin \
    n_errors++; $display("wrong value %s exp %h seen %h", n, e, s); end end
module tb_top;
    import firs_pkg::*;
    logic        mclk_i = 1'b0, rst_n_i = 1'b0, write_in_progress_flag = 1'b0, so, oe, wr_ok;
    logic        s_open, wip_o;
    logic        oe_seen = 1'b0;
    logic [3:0]  bp = 4'h0;
    logic [11:0] wr_sec = 12'h000, open_sec, sa, sb;
    logic [9:0]  rom_addr;
    logic [7:0]  rom_data, sh, ex;
    logic [7:0]  exp_q[$];
    firs_pins_s  pins;
    int          n_errors = 0, samples_checked = 0, nb = 0;
    int          seed = 32'hae8d;
    function automatic logic [7:0] rom_f(input logic [9:0] a);
        return a[7:0] ^ {a[9:8], 6'h35};
    endfunction : rom_f
    assign rom_data = rom_f(rom_addr);
    always #12.5 mclk_i = ~mclk_i;
    firs_top i_firs_top (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .pins_i(pins),
        .so_o(so), .so_oe_o(oe), .write_in_progress_flag_i(write_in_progress_flag),
        .block_protect_bit0_i(bp[0]), .block_protect_bit1_i(bp[1]),
        .block_protect_bit2_i(bp[2]), .block_protect_bit3_i(bp[3]),
        .wr_sector_i(wr_sec), .wr_allowed_o(wr_ok), .sector_open_o(s_open),
        .open_sector_o(open_sec), .write_in_progress_flag_o(wip_o),
        .rom_addr_o(rom_addr), .rom_data_i(rom_data));
    firs_host i_firs_host (.mclk_i(mclk_i), .pins_o(pins));
    // Result watcher: bit from the previous fall, one byte per eight
    always @(negedge pins.sck) begin
        if (oe === 1'b1) begin
            sh = {sh[6:0], so};
            nb++;
            if (nb == 8) begin
                nb = 0;
                ex = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hxx;
                `CHK("read byte", ex, sh)
            end
        end
    end
    always @(posedge mclk_i) if (oe === 1'b1) oe_seen <= 1'b1;
    task automatic end_of_test();
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_of_test
    task automatic cmd(input logic [7:0] op, input logic [31:0] a,
                       input int na, input int nd);
        i_firs_host.start_frame();
        i_firs_host.send_byte(op);
        for (int i = 0; i < na; i++) i_firs_host.send_byte(a[31-8*i -: 8]);
        for (int i = 0; i < nd; i++) i_firs_host.send_byte(8'($random(seed)));
        i_firs_host.end_frame();
    endtask : cmd
    task automatic row_rd(input logic [1:0] r, input logic [7:0] b,
                          input int n, input logic e);
        for (int i = 0; i < n; i++) if (e) exp_q.push_back(rom_f({r, b + 8'(i)}));
        cmd(`FIRS_OP_ROW_READ, {10'h000, r, 4'h0, b, 8'h00}, 4, n);
    endtask : row_rd
    task automatic sec_chk(input logic o, input logic [11:0] s,
                           input logic [11:0] w, input logic al);
        wr_sec = w;
        repeat (8) @(negedge mclk_i);
        `CHK("sector open", o, s_open)
        if (o) `CHK("open sector", s, open_sec)
        `CHK("write allowed", al, wr_ok)
    endtask : sec_chk
    initial begin
        #2000000;
        n_errors++;
        end_of_test();
    end
    initial begin
        repeat (4) @(negedge mclk_i);
        rst_n_i = 1'b1;
        repeat (8) @(negedge mclk_i);
        for (int r = 0; r < 4; r++) row_rd(2'(r), 8'h00, 3, 1'b1);
        row_rd(2'($random(seed)), 8'hfc, 4, 1'b1);
        row_rd(2'($random(seed)), 8'($random(seed)) & 8'hf0, 2, 1'b1);
        `CHK("results left", 0, exp_q.size())
        write_in_progress_flag = 1'b1;
        oe_seen = 1'b0;
        repeat (100) @(negedge mclk_i);
        `CHK("busy flag", 1'b1, wip_o)
        row_rd(2'h1, 8'h00, 2, 1'b0);
        `CHK("read while busy", 1'b0, oe_seen)
        write_in_progress_flag = 1'b0;
        repeat (8) @(negedge mclk_i);
        `CHK("busy flag", 1'b0, wip_o)
        bp = 4'h5;
        sa = 12'($random(seed));
        sb = sa ^ 12'h0a5;
        cmd(`FIRS_OP_SECTOR_OPEN, {sa, 12'($random(seed)), 8'h00}, 3, 0);
        sec_chk(1'b1, sa, sa, 1'b1);
        sec_chk(1'b1, sa, sb, 1'b0);
        cmd(`FIRS_OP_SECTOR_OPEN, {sb, 12'hfff, 8'h00}, 3, 0);
        sec_chk(1'b1, sb, sa, 1'b0);
        for (int k = 0; k < 4; k++) begin
            bp = 4'h1 << k;
            sec_chk(1'b1, sb, sa, 1'b0);
        end
        bp = 4'h0;
        sec_chk(1'b1, sb, sa, 1'b1);
        bp = 4'h8;
        cmd(`FIRS_OP_SECTOR_CLOSE, 32'h0, 0, 0);
        sec_chk(1'b0, sb, sb, 1'b0);
        oe_seen = 1'b0;
        cmd(8'h03, {sa, 20'h00000}, 3, 1);
        sec_chk(1'b0, sb, sb, 1'b0);
        `CHK("unknown command", 1'b0, oe_seen)
        // Long read of 40 bytes from byte 10h fills the byte buffer and runs past its depth, staying inside the row
        row_rd(2'h2, 8'h10, 40, 1'b1);
        `CHK("long read left", 0, exp_q.size())
        `CHK("output enable after frame", 1'b0, oe)
        `CHK("sector after read", 1'b0, s_open)
        end_of_test();
    end
endmodule : tb_top
